// [verilog/cycle_timing_regs.vh]
// Purpose: constants for the instruction cycle timing block
// Assumes: one system clock domain, no software-visible registers
// Notes:   phase codes are one-hot, one per system clock of a cycle
// Functional notes
// (RULE_01) One instruction cycle is made of exactly four system clocks.
// (RULE_02) Any instruction not listed as an exception takes one cycle.
// (RULE_03) Branch, call and table read instructions take two cycles.
// (RULE_04) Jump, call, return and return-from-interrupt add one cycle.
// (RULE_05) A write to the program counter low byte jumps and adds a cycle.
// (RULE_06) A conditional skip adds a cycle only when the skip is taken.
// (RULE_07) Moves exist from register to accumulator, back, and immediate.
// (RULE_08) The extra cycle discards the prefetched word and refetches.
`ifndef CYCLE_TIMING_REGS_VH
`define CYCLE_TIMING_REGS_VH
`define SYS_CLK_NS        100
`define PHASES_PER_CYCLE  4
`define PHASE_W           4
`define PHASE_1           4'h1
`define PHASE_2           4'h2
`define PHASE_3           4'h4
`define PHASE_4           4'h8
`define MOVE_W            2
`define MOVE_NONE         2'h0
`define MOVE_REG_TO_ACC   2'h1
`define MOVE_ACC_TO_REG   2'h2
`define MOVE_IMM_TO_ACC   2'h3
`define DATA_W            8
`define PHASE_RST         4'h1
`define EXTRA_RST         1'h0
`define ACC_RST           8'h00
`define WDATA_RST         8'h00
`define WE_RST            1'h0
`endif

// [verilog/instruction_cycle_timing.v]
// Purpose: sequence instruction cycles and stretch two-cycle instructions
// Assumes: decoder supplies class flags during the executing cycle
// Notes:   clk_en low freezes all state
`timescale 1ns/100ps
`include "cycle_timing_regs.vh"
module instruction_cycle_timing (
    input  wire                 sys_clk,
    input  wire                 resetn,
    input  wire                 clk_en,
    input  wire                 is_branch,
    input  wire                 is_call,
    input  wire                 is_return,
    input  wire                 is_table_read,
    input  wire                 writes_pcl,
    input  wire                 is_skip,
    input  wire                 skip_taken,
    input  wire [`MOVE_W-1:0]   move_kind,
    input  wire [`DATA_W-1:0]   reg_data,
    input  wire [`DATA_W-1:0]   imm_data,
    output reg  [`PHASE_W-1:0]  phase,
    output wire                 cycle_end,
    output reg                  extra_cycle,
    output wire                 execute_en,
    output wire                 fetch_en,
    output wire                 flush_fetch,
    output reg  [`DATA_W-1:0]   acc,
    output reg  [`DATA_W-1:0]   reg_wdata,
    output reg                  reg_we
);

    // class flags gathered into one word, branch in the top bit and the
    // skip outcome in the bottom bit
    wire [6:0]          class_word;

    // decodes of the instruction that is executing now
    wire                stretch;
    wire                last_phase;
    wire                move_to_acc;
    wire                move_to_reg;

    // combinational next values of every register in the block
    reg  [`PHASE_W-1:0] phase_next;
    reg                 extra_next;
    reg  [`DATA_W-1:0]  acc_next;
    reg  [`DATA_W-1:0]  wdata_next;
    reg                 we_next;

    // source picked for a move into the accumulator
    reg  [`DATA_W-1:0]  acc_source;

    // class test shared by the end-of-cycle logic and the flush output;
    // a skip only counts once its test has really chosen to skip, so a
    // skip that falls through costs no more than an ordinary instruction
    function needs_extra;
        input [6:0] cls;
        begin
            // (RULE_03) (RULE_04) (RULE_05) (RULE_06) two-cycle classes
            needs_extra = (|cls[6:2]) | (cls[1] & cls[0]);
        end
    endfunction

    // one move code compare, used by every move decode below
    function is_move;
        input [`MOVE_W-1:0] kind;
        input [`MOVE_W-1:0] code;
        begin
            is_move = (kind == code);
        end
    endfunction

    // rotation of the one-hot phase ring; a code that is not one-hot
    // (an upset, say) is forced back to phase one instead of sticking
    function [`PHASE_W-1:0] rotate_phase;
        input [`PHASE_W-1:0] now;
        begin
            case (now)
                `PHASE_1: begin
                    rotate_phase = `PHASE_2;
                end
                `PHASE_2: begin
                    rotate_phase = `PHASE_3;
                end
                `PHASE_3: begin
                    rotate_phase = `PHASE_4;
                end
                `PHASE_4: begin
                    rotate_phase = `PHASE_1;
                end
                default: begin
                    rotate_phase = `PHASE_1;
                end
            endcase
        end
    endfunction

    // class word and its decodes
    assign class_word  = {is_branch, is_call, is_return, is_table_read,
                          writes_pcl, is_skip, skip_taken};
    assign stretch     = needs_extra(class_word);
    assign last_phase  = (phase == `PHASE_4);

    // (RULE_07) register and immediate forms both land in the accumulator
    assign move_to_acc = is_move(move_kind, `MOVE_REG_TO_ACC)
                       | is_move(move_kind, `MOVE_IMM_TO_ACC);
    assign move_to_reg = is_move(move_kind, `MOVE_ACC_TO_REG);

    // (RULE_01) a cycle ends on the fourth enabled clock
    assign cycle_end   = clk_en & last_phase;

    // (RULE_02) ordinary instructions execute in their one cycle; the
    // added cycle of a stretched instruction executes nothing
    assign execute_en  = cycle_end & ~extra_cycle;

    // (RULE_08) extra cycle fetches from the new counter
    assign fetch_en    = cycle_end;

    // (RULE_08) the word fetched behind a stretched one is thrown away;
    // the flags are only meaningful while execute_en is high
    assign flush_fetch = execute_en & stretch;

    // next phase; clk_en low holds the ring where it is
    always @* begin
        phase_next = phase;
        if (clk_en) begin
            // (RULE_01) rotate through four clocks
            phase_next = rotate_phase(phase);
        end
    end

    // phase ring register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= `PHASE_RST;
        end else begin
            phase <= phase_next;
        end
    end

    // next extra cycle flag; it is set once per stretched instruction and
    // cleared at the end of the added cycle, so stretches never chain even
    // if the decoder leaves the class flags standing
    always @* begin
        extra_next = extra_cycle;
        if (cycle_end) begin
            // (RULE_08) discard prefetched word for one cycle
            extra_next = ~extra_cycle & stretch;
        end
    end

    // extra cycle register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            extra_cycle <= `EXTRA_RST;
        end else begin
            extra_cycle <= extra_next;
        end
    end

    // accumulator source: immediate when asked for, else the register
    always @* begin
        acc_source = reg_data;
        if (is_move(move_kind, `MOVE_IMM_TO_ACC)) begin
            acc_source = imm_data;
        end
    end

    // next values of the move results; moves commit only at the end of
    // an executing cycle, so the added cycle cannot repeat a move
    always @* begin
        acc_next   = acc;
        wdata_next = reg_wdata;
        we_next    = reg_we;
        if (clk_en) begin
            // write strobe lasts one enabled clock
            we_next = `WE_RST;
            if (execute_en & move_to_acc) begin
                // (RULE_07) register or immediate into accumulator
                acc_next = acc_source;
            end
            if (execute_en & move_to_reg) begin
                // (RULE_07) accumulator out to a register
                wdata_next = acc;
                we_next    = 1'h1;
            end
        end
    end

    // accumulator register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc <= `ACC_RST;
        end else begin
            acc <= acc_next;
        end
    end

    // register write data; held between writes so a slow consumer can
    // still read it after the strobe has gone
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_wdata <= `WDATA_RST;
        end else begin
            reg_wdata <= wdata_next;
        end
    end

    // register write strobe
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_we <= `WE_RST;
        end else begin
            reg_we <= we_next;
        end
    end

    // limitation: the class and move inputs must be settled by the fourth
    // phase; nothing here latches them earlier, which saves a stage of
    // flip-flops at the cost of a tighter decoder path
endmodule // instruction_cycle_timing

// [bench/cycle_properties.sv]
// Purpose: timing properties of the cycle block
// Assumes: one clock, async low reset
// Notes:   bound below
`timescale 1ns/100ps
module cycle_properties (
    input wire       sys_clk, resetn, clk_en, is_branch, is_call,
    input wire       is_return, is_table_read, writes_pcl, is_skip,
    input wire       skip_taken, cycle_end, extra_cycle, execute_en,
    input wire       flush_fetch, reg_we,
    input wire [1:0] move_kind,
    input wire [7:0] imm_data, acc, reg_wdata,
    input wire [3:0] phase
);
    // transfers and taken skips stretch
    wire need = is_branch | is_call | is_return | is_table_read
        | writes_pcl | (is_skip & skip_taken);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wrap_a: assert property (cycle_end |=> phase == 4'h1)
        else $error("wrap");
    end_a: assert property (cycle_end == (clk_en & phase[3]))
        else $error("end");
    two_a: assert property (execute_en & need |=> extra_cycle)
        else $error("stretch");
    one_a: assert property (execute_en & !need |=> !extra_cycle)
        else $error("single");
    flush_a: assert property (flush_fetch == (execute_en & need))
        else $error("flush");
    exec_a: assert property (execute_en == (cycle_end & !extra_cycle))
        else $error("exec");
    imm_a: assert property (execute_en & move_kind == 2'h3
        |=> acc == $past(imm_data)) else $error("imm");
    wr_a: assert property (execute_en & move_kind == 2'h2
        |=> reg_we & reg_wdata == $past(acc)) else $error("write");
    cover property (flush_fetch);
    cover property (execute_en & is_skip & !skip_taken);
    cover property (reg_we);
endmodule // cycle_properties
bind instruction_cycle_timing cycle_properties chk (.*);

// [bench/testbench.sv]
// Purpose: self-checking bench for cycle timing
// Assumes: inputs move 1 ns after rising edges
// Notes:   rows hold stretch flag over class flags
`timescale 1ns/100ps
module testbench;
    reg        c = 0, rn = 0, en = 1;
    reg  [6:0] f = 0;
    reg  [1:0] mk = 0;
    reg  [7:0] ex = 0;
    wire [3:0] ph;
    wire       ee, ff, ce, xc, fe, we;
    wire [7:0] rw;
    wire [7:0] acc;
    integer    fails = 0, n_checks = 0, i, n;
    reg  [7:0] rows [0:7] = '{8'h00, 8'hC0, 8'hA0, 8'h90,
                              8'h88, 8'h84, 8'h02, 8'h83};
    instruction_cycle_timing uut (.sys_clk(c), .resetn(rn), .clk_en(en),
        .is_branch(f[6]), .is_call(f[5]), .is_return(f[4]),
        .is_table_read(f[3]), .writes_pcl(f[2]), .is_skip(f[1]),
        .skip_taken(f[0]), .move_kind(mk), .reg_data(8'h5A),
        .imm_data(8'hC3), .phase(ph), .cycle_end(ce), .extra_cycle(xc),
        .execute_en(ee), .fetch_en(fe), .flush_fetch(ff), .acc(acc),
        .reg_wdata(rw), .reg_we(we));
    always #50 c = ~c;
    task chk(input [7:0] s, e, input [47:0] w);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                fails = fails + 1;
                $display("unexpected %s exp %h seen %h", w, e, s);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // watchdog well past the roughly 66 clock cycles of tests
    initial begin
        #30000 fails = fails + 1;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge c);
        chk({4'h0, ph}, 8'h01, "phase");
        #1 rn = 1;
        while (!ee) @(posedge c) #1;
        for (i = 0; i < 8; i = i + 1) begin
            f = rows[i][6:0];
            mk = i[1:0];
            #1 chk({7'h0, ff}, {7'h0, rows[i][7]}, "flush");
            chk({6'h0, ce, fe}, 8'h03, "endfet");
            n = 0;
            do begin
                @(posedge c) #1 n = n + 1;
                if (n == 1) begin
                    chk({7'h0, xc}, {7'h0, rows[i][7]}, "extra");
                    chk({7'h0, we}, {7'h0, mk == 2'h2}, "we");
                    if (mk == 2'h2) chk(rw, ex, "wdata");
                end
                if (n == 4)
                    chk({7'h0, fe & ~ee}, {7'h0, rows[i][7]}, "fetch");
            end while (!ee);
            chk(n[7:0], rows[i][7] ? 8'h08 : 8'h04, "gap");
            ex = mk == 2'h1 ? 8'h5A : mk == 2'h3 ? 8'hC3 : ex;
            chk(acc, ex, "acc");
        end
        en = 0;
        repeat (3) @(posedge c);
        #1 chk({4'h0, ph}, 8'h08, "freeze");
        en = 1;
        rn = 0;
        #1 chk({4'h0, ph}, 8'h01, "rphase");
        chk(acc, 8'h00, "racc");
        chk({7'h0, xc}, 8'h00, "rextra");
        @(posedge c) #1 rn = 1;
        @(posedge c) #1 chk({4'h0, ph}, 8'h02, "phase2");
        tally_and_finish;
    end
endmodule // testbench
